/* File: rtl/wsic_pkg.sv */
// Package: register map, field positions and reset values of the block
package wsic_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_AUX_CTRL = 8'h00;
    localparam logic [7:0] OFS_AUX_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_ONE = 8'h14;
    localparam logic [7:0] OFS_RSVD_SIX = 8'h18;
    localparam logic [7:0] OFS_IRQ_TWO = 8'h1c;
    // ext_ctrl_irq_one fields
    localparam int B_WAKE_IRQ = 4;
    localparam int B_WAKE_IRQ_EN = 3;
    localparam int B_HOST_WAKE = 2;
    localparam int B_WAKE_SEL = 1;
    localparam int B_SUSPEND = 0;
    // ext_ctrl_irq_two fields
    localparam int B_QUICK_SUSP = 15;
    localparam int B_RX_POLL = 13;
    localparam int B_CHAIN_DIS = 12;
    localparam int B_TMR_IRQ = 11;
    localparam int B_TMR_IRQ_EN = 10;
    localparam int B_MRE_IRQ = 9;
    localparam int B_MRE_IRQ_EN = 8;
    // aux_ctrl fields
    localparam int B_GLOBAL_EN = 0;
    localparam int B_HALT = 1;
    localparam int B_SOFT_RST = 2;
    localparam int B_RELOAD_LO = 8;
    // aux_stat fields
    localparam int B_ST_SUMMARY = 0;
    localparam int B_ST_WAKE_MODE = 1;
    localparam int B_ST_SUSPENDED = 2;
    localparam int B_ST_COUNT_LO = 8;
    // Widths and reset values
    localparam int TMR_W = 6;
    localparam logic [TMR_W-1:0] TMR_RELOAD_RST = 6'h3f;
    localparam logic [1:0] RST_SYNC_RST = 2'h0;
    // Suspend sequencer, Gray along run -> wait -> suspended
    typedef enum logic [1:0] {
        SP_RUN = 2'h0,
        SP_FAST = 2'h1,
        SP_SUSP = 2'h3,
        SP_FLUSH = 2'h2
    } susp_e;
endpackage

/* File: rtl/sw_timer.sv */
// Software timer: free running down counter with reload and expiry pulse
`timescale 1ns/1ps
module sw_timer #(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] reload,
    output logic [W-1:0] count,
    output logic expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic exp;
    } tmr_s;
    tmr_s q, d;

    // At zero: flag expiry and reload at once, counting resumes
    always_comb begin
        d = q;
        d.exp = 1'b0;
        if (q.cnt == '0) begin
            d.exp = 1'b1;
            d.cnt = reload;
        end else begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count = q.cnt;
    assign expired = q.exp;
endmodule // sw_timer

/* File: rtl/wake_suspend_irq_control.sv */
// Wake frame, suspend, poll demand and interrupt control registers
//
// Behaviour
// - Wake frame in wake mode sets flag
// - Wake flag drives line with both enables
// - Wake flag: write one clears, resets clear
// - Wake enable gates summary, survives halt
// - Wake mode: select and (power or enable)
// - Wake select/enable cleared by resets only
// - Suspend bit reads one once suspended
// - Suspend set accepted only while not halted
// - Writing zero, resets or halt end suspend
// - Resume keeps ring positions, no reinit
// - Suspend style chosen when bit set
// - Fast: finish started work, start nothing
// - Flush: empty queues before entering suspend
// - Write one sets rx poll demand
// - Descriptor fetch or resets clear demand
// - Chain poll disable stops automatic polling
// - Timer zero sets flag and reloads
// - Timer flag: enable gates, write one clears
// - Turnaround not low sets read error
// - Read error flag: enable gates, clears
// - Indicator bits clear on write one
// - Upper halves and reserved ignore writes
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module wake_suspend_irq_control #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_good_input,
    input wire logic wake_frame_rx,
    input wire logic mdio_turn_high,
    input wire logic rx_desc_fetch,
    input wire logic tx_poll_demand,
    input wire logic poll_interval_tick,
    input wire logic dma_active,
    input wire logic frame_active,
    input wire logic tx_queue_empty,
    input wire logic rx_buf_empty,
    output logic irq_summary,
    output logic pci_irq_n,
    output logic wake_mode_active,
    output logic suspended,
    output logic no_new_work,
    output logic flush_req,
    output logic rx_poll_go,
    output logic tx_poll_go,
    output logic chain_poll_disable,
    output logic ring_reinit
);
    import wsic_pkg::*;

    typedef struct packed {
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic [1:0] pg_sync;
        logic global_en;
        logic halt;
        logic [TMR_W-1:0] reload;
        logic wake_irq;
        logic wake_irq_en;
        logic host_wake;
        logic wake_sel;
        logic susp_req;
        logic quick_en;
        logic quick_mode;
        susp_e susp;
        logic rx_poll;
        logic chain_dis;
        logic tmr_irq;
        logic tmr_irq_en;
        logic mre_irq;
        logic mre_irq_en;
        logic summary;
        logic line_n;
        logic wake_mode;
        logic rx_go;
        logic tx_go;
        logic reinit;
        logic susp_done;
        logic no_new;
        logic flushing;
    } state_s;

    state_s q, d;
    logic [1:0] rst_sync_q;
    logic rst_ok_n;
    logic [TMR_W-1:0] tmr_count;
    logic tmr_expired;
    logic setup, wr_acc, wr_aux, wr_one, wr_two;
    logic s_reset, halt_set, clr_soft;
    logic [31:0] rd_mux;
    logic rd_ok;

    ////////////////////////////////////////////////////////////////////
    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= RST_SYNC_RST;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_ok_n = rst_sync_q[1];

    // Timer runs on the reload value held in aux_ctrl
    sw_timer #(
        .W(TMR_W)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_ok_n),
        .reload(q.reload),
        .count(tmr_count),
        .expired(tmr_expired)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus decode; writes land on the access edge with pready high
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && q.ready && pwrite;
    assign wr_aux = wr_acc && (paddr == OFS_AUX_CTRL);
    assign wr_one = wr_acc && (paddr == OFS_IRQ_ONE);
    assign wr_two = wr_acc && (paddr == OFS_IRQ_TWO);
    assign s_reset = wr_aux && pwdata[B_SOFT_RST];
    assign halt_set = wr_aux && pwdata[B_HALT];
    // Soft reset and halt share many clears
    assign clr_soft = s_reset || halt_set;

    // Read view; upper halves and the reserved word read zero
    always_comb begin
        rd_mux = 32'h0;
        rd_ok = 1'b1;
        case (paddr)
            OFS_AUX_CTRL: begin
                rd_mux[B_GLOBAL_EN] = q.global_en;
                rd_mux[B_HALT] = q.halt;
                rd_mux[B_RELOAD_LO +: TMR_W] = q.reload;
            end
            OFS_AUX_STAT: begin
                rd_mux[B_ST_SUMMARY] = q.summary;
                rd_mux[B_ST_WAKE_MODE] = q.wake_mode;
                rd_mux[B_ST_SUSPENDED] = (q.susp == SP_SUSP);
                rd_mux[B_ST_COUNT_LO +: TMR_W] = tmr_count;
            end
            OFS_IRQ_ONE: begin
                rd_mux[B_WAKE_IRQ] = q.wake_irq;
                rd_mux[B_WAKE_IRQ_EN] = q.wake_irq_en;
                rd_mux[B_HOST_WAKE] = q.host_wake;
                rd_mux[B_WAKE_SEL] = q.wake_sel;
                rd_mux[B_SUSPEND] = (q.susp == SP_SUSP);
            end
            OFS_RSVD_SIX: begin
                rd_mux = 32'h0;
            end
            OFS_IRQ_TWO: begin
                rd_mux[B_QUICK_SUSP] = q.quick_en;
                rd_mux[B_RX_POLL] = q.rx_poll;
                rd_mux[B_CHAIN_DIS] = q.chain_dis;
                rd_mux[B_TMR_IRQ] = q.tmr_irq;
                rd_mux[B_TMR_IRQ_EN] = q.tmr_irq_en;
                rd_mux[B_MRE_IRQ] = q.mre_irq;
                rd_mux[B_MRE_IRQ_EN] = q.mre_irq_en;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Next state of the whole block
    always_comb begin
        d = q;
        // Zero wait state slave: answer in the first access cycle
        d.ready = setup;
        d.slverr = setup && !rd_ok;
        d.rdata = setup ? rd_mux : q.rdata;
        // First sync flop feeds only the second
        d.pg_sync = {q.pg_sync[0], power_good_input};

        if (wr_aux) begin
            d.global_en = pwdata[B_GLOBAL_EN];
            d.halt = pwdata[B_HALT];
            d.reload = pwdata[B_RELOAD_LO +: TMR_W];
        end

        // Enables and mode bits, kept across halt
        if (wr_one) begin
            d.wake_irq_en = pwdata[B_WAKE_IRQ_EN];
            d.host_wake = pwdata[B_HOST_WAKE];
            d.wake_sel = pwdata[B_WAKE_SEL];
        end
        if (s_reset) begin
            d.wake_irq_en = 1'b0;
            d.host_wake = 1'b0;
            d.wake_sel = 1'b0;
        end

        // Wake mode entry
        d.wake_mode = q.wake_sel && (q.pg_sync[1] || q.host_wake);

        // Wake flag: event set beats a host clear
        if (wr_one && pwdata[B_WAKE_IRQ]) begin
            d.wake_irq = 1'b0;
        end
        if (q.wake_mode && wake_frame_rx) begin
            d.wake_irq = 1'b1;
        end
        if (clr_soft) begin
            d.wake_irq = 1'b0;
        end

        // Quick suspend style bit
        if (wr_two) begin
            d.quick_en = pwdata[B_QUICK_SUSP];
        end
        if (clr_soft) begin
            d.quick_en = 1'b0;
        end

        // Suspend request; style latched from the current quick bit
        if (wr_one) begin
            if (!pwdata[B_SUSPEND]) begin
                d.susp_req = 1'b0;
            end else if (!q.halt && !q.susp_req) begin
                d.susp_req = 1'b1;
                d.quick_mode = q.quick_en;
            end
        end
        if (clr_soft) begin
            d.susp_req = 1'b0;
        end

        // Suspend sequencer
        case (q.susp)
            SP_RUN: begin
                if (q.susp_req) begin
                    d.susp = q.quick_mode ? SP_FAST : SP_FLUSH;
                end
            end
            SP_FAST: begin
                // Only work already begun may finish
                if (!dma_active && !frame_active) begin
                    d.susp = SP_SUSP;
                end
            end
            SP_FLUSH: begin
                // Queues must empty; can take long under traffic
                if (!dma_active && !frame_active &&
                    tx_queue_empty && rx_buf_empty) begin
                    d.susp = SP_SUSP;
                end
            end
            SP_SUSP: begin
                d.susp = SP_SUSP;
            end
            default: begin
                d.susp = SP_RUN;
            end
        endcase
        if (!q.susp_req) begin
            d.susp = SP_RUN;
        end
        // Status pins registered from the next state, same timing as state
        d.susp_done = (d.susp == SP_SUSP);
        d.no_new = (d.susp == SP_FAST) || (d.susp == SP_SUSP);
        d.flushing = (d.susp == SP_FLUSH);

        // Ring restart only on soft reset or halt, never on resume
        d.reinit = clr_soft;

        // Receive poll demand: set by write one, cleared by fetch
        if (rx_desc_fetch) begin
            d.rx_poll = 1'b0;
        end
        if (wr_two && pwdata[B_RX_POLL]) begin
            d.rx_poll = 1'b1;
        end
        if (s_reset) begin
            d.rx_poll = 1'b0;
        end

        // Chain poll disable survives soft reset and halt
        if (wr_two) begin
            d.chain_dis = pwdata[B_CHAIN_DIS];
            d.tmr_irq_en = pwdata[B_TMR_IRQ_EN];
            d.mre_irq_en = pwdata[B_MRE_IRQ_EN];
        end

        // Poll strobes: demand always, interval tick unless disabled
        d.rx_go = q.rx_poll || (!q.chain_dis && poll_interval_tick);
        d.tx_go = tx_poll_demand ||
                  (!q.chain_dis && poll_interval_tick);

        // Timer and read error flags, write one clears, set wins
        if (wr_two && pwdata[B_TMR_IRQ]) begin
            d.tmr_irq = 1'b0;
        end
        if (tmr_expired) begin
            d.tmr_irq = 1'b1;
        end
        if (wr_two && pwdata[B_MRE_IRQ]) begin
            d.mre_irq = 1'b0;
        end
        if (mdio_turn_high) begin
            d.mre_irq = 1'b1;
        end

        // Summary and line follow flags and enables one clock later
        d.summary = (q.wake_irq && q.wake_irq_en) ||
                    (q.tmr_irq && q.tmr_irq_en) ||
                    (q.mre_irq && q.mre_irq_en);
        d.line_n = !((q.wake_irq && q.wake_irq_en && q.global_en) ||
                     (q.tmr_irq && q.tmr_irq_en) ||
                     (q.mre_irq && q.mre_irq_en));
    end

    // Single state register; hard reset clears all but line_n (set high) and reload (3f)
    always_ff @(posedge clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            q <= '0;
            q.line_n <= 1'b1;
            q.reload <= TMR_RELOAD_RST;
            q.susp <= SP_RUN;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.slverr;
    assign irq_summary = q.summary;
    assign pci_irq_n = q.line_n;
    assign wake_mode_active = q.wake_mode;
    assign suspended = q.susp_done;
    assign no_new_work = q.no_new;
    assign flush_req = q.flushing;
    assign rx_poll_go = q.rx_go;
    assign tx_poll_go = q.tx_go;
    assign chain_poll_disable = q.chain_dis;
    assign ring_reinit = q.reinit;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_ok_n);

    wake_set_a: assert property (
        q.wake_mode && wake_frame_rx && !clr_soft |=> q.wake_irq)
        else $error("wake frame did not set flag");

    wake_line_a: assert property (
        q.wake_irq && q.wake_irq_en && q.global_en |=> !pci_irq_n)
        else $error("wake flag did not drive line");

    wake_clr_a: assert property (
        clr_soft |=> !q.wake_irq)
        else $error("wake flag survived reset or halt");

    wake_en_keep_a: assert property (
        halt_set && !s_reset |=> q.wake_irq_en == $past(q.wake_irq_en))
        else $error("halt changed wake enable");

    wake_mode_a: assert property (
        q.wake_sel && q.host_wake |=> wake_mode_active)
        else $error("wake mode not entered");

    susp_halt_a: assert property (
        wr_one && pwdata[B_SUSPEND] && q.halt && !q.susp_req
        |=> !q.susp_req)
        else $error("suspend accepted while halted");

    susp_exit_a: assert property (
        wr_one && !pwdata[B_SUSPEND] |=> ##1 !suspended)
        else $error("suspend not left");

    fast_wait_a: assert property (
        q.susp == SP_FAST && (dma_active || frame_active)
        |=> !suspended)
        else $error("fast suspend entered while busy");

    flush_wait_a: assert property (
        q.susp == SP_FLUSH && !tx_queue_empty |=> !suspended)
        else $error("flush suspend entered with queued data");

    rx_poll_a: assert property (
        wr_two && pwdata[B_RX_POLL] && !s_reset |=> q.rx_poll ##1 rx_poll_go)
        else $error("receive demand not raised");

    chain_a: assert property (
        q.chain_dis && !q.rx_poll |=> !rx_poll_go)
        else $error("automatic poll while disabled");

    tmr_set_a: assert property (
        tmr_expired |=> q.tmr_irq)
        else $error("timer expiry lost");

    mre_set_a: assert property (
        mdio_turn_high |=> q.mre_irq [*1] ##1
        (irq_summary || !$past(q.mre_irq_en)))
        else $error("read error not reported");

    summary_a: assert property (
        irq_summary == $past((q.tmr_irq && q.tmr_irq_en) ||
                             (q.mre_irq && q.mre_irq_en) ||
                             (q.wake_irq && q.wake_irq_en)))
        else $error("summary not OR of enabled flags");

    fast_cov: cover property (q.susp == SP_FAST ##[1:50] suspended);
    flush_cov: cover property (q.susp == SP_FLUSH ##[1:50] suspended);
    wake_cov: cover property (q.wake_irq && !pci_irq_n);
    tmr_cov: cover property (tmr_expired && wr_two && pwdata[B_TMR_IRQ]);
endmodule // wake_suspend_irq_control

/* File: bench/mac_env_model.sv */
// Model of the buffer manager and MAC activity around the control block
`timescale 1ns/1ps
module mac_env_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start_work,
    input wire logic load_queue,
    input wire logic fetch_en,
    input wire logic flush_req,
    input wire logic rx_poll_go,
    output logic dma_active,
    output logic frame_active,
    output logic tx_queue_empty,
    output logic rx_buf_empty,
    output logic rx_desc_fetch
);
    logic [3:0] busy_q;
    logic [3:0] queued_q;
    ////////////////////////////////////////////////////////////////////////
    // Work already begun runs out; queues drain only while a flush runs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 4'h0;
            queued_q <= 4'h0;
            rx_desc_fetch <= 1'b0;
        end else begin
            busy_q <= start_work ? 4'hc : busy_q - {3'h0, busy_q != 4'h0};
            if (load_queue) begin
                queued_q <= 4'h5;
            end else if (flush_req && queued_q != 4'h0) begin
                queued_q <= queued_q - 4'h1;
            end
            // Fetch answers a poll one cycle late, as a slow manager would
            rx_desc_fetch <= fetch_en && rx_poll_go && !rx_desc_fetch;
        end
    end
    // Frame ends before its DMA; tx side empties before rx side
    assign dma_active = busy_q != 4'h0;
    assign frame_active = busy_q > 4'h6;
    assign tx_queue_empty = queued_q < 4'h3;
    assign rx_buf_empty = queued_q == 4'h0;
endmodule // mac_env_model

/* File: bench/tb_top.sv */
// Self-checking bench for the wake, suspend and interrupt control block
`timescale 1ns/1ps
module tb_top;
    import wsic_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic power_good_input, wake_frame_rx, mdio_turn_high, rx_desc_fetch;
    logic tx_poll_demand, poll_interval_tick, dma_active, frame_active;
    logic tx_queue_empty, rx_buf_empty, irq_summary, pci_irq_n;
    logic wake_mode_active, suspended, no_new_work, flush_req, ring_reinit;
    logic rx_poll_go, tx_poll_go, chain_poll_disable;
    logic start_work, load_queue, fetch_en;
    int n_mismatch, num_checks, cycles, reinit_cnt, n;
    ////////////////////////////////////////////////////////////////////////
    wake_suspend_irq_control u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_good_input(power_good_input), .wake_frame_rx(wake_frame_rx),
        .mdio_turn_high(mdio_turn_high), .rx_desc_fetch(rx_desc_fetch),
        .tx_poll_demand(tx_poll_demand),
        .poll_interval_tick(poll_interval_tick), .dma_active(dma_active),
        .frame_active(frame_active), .tx_queue_empty(tx_queue_empty),
        .rx_buf_empty(rx_buf_empty), .irq_summary(irq_summary),
        .pci_irq_n(pci_irq_n), .wake_mode_active(wake_mode_active),
        .suspended(suspended), .no_new_work(no_new_work),
        .flush_req(flush_req), .rx_poll_go(rx_poll_go),
        .tx_poll_go(tx_poll_go), .chain_poll_disable(chain_poll_disable),
        .ring_reinit(ring_reinit));
    mac_env_model u_env (.clk(clk), .rst_n(rst_n), .start_work(start_work),
        .load_queue(load_queue), .fetch_en(fetch_en), .flush_req(flush_req),
        .rx_poll_go(rx_poll_go), .dma_active(dma_active),
        .frame_active(frame_active), .tx_queue_empty(tx_queue_empty),
        .rx_buf_empty(rx_buf_empty), .rx_desc_fetch(rx_desc_fetch));
    ////////////////////////////////////////////////////////////////////////
    // Clock, cycle ceiling against hangs, reinit pulse counter
    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (ring_reinit === 1'b1) reinit_cnt++;
        if (cycles == 6000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Waits settle on the falling edge so checks never race the design
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // APB transfer; held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Answer taken at the rising edge that sees pready high
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        rd_v = prdata;
        last_err = pslverr;
        check("pready", pready, 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input [31:0] e, m, string nm);
        apb(1'b0, a, 32'h0);
        check(nm, rd_v & m, e);
    endtask
    task automatic pulse_wake;
        @(posedge clk);
        wake_frame_rx <= 1'b1;
        @(posedge clk);
        wake_frame_rx <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_bus;
        rdc(OFS_IRQ_ONE, 32'h0, '1, "one reset");
        rdc(OFS_IRQ_TWO, 32'h0, 32'hfffff7ff, "two reset");
        rdc(OFS_AUX_CTRL, {TMR_RELOAD_RST, 8'h0}, 32'h3f00, "reload");
        check("line idle", pci_irq_n, 1);
        wr(OFS_RSVD_SIX, 32'hffffffff);
        rdc(OFS_RSVD_SIX, 32'h0, '1, "reserved");
        wr(OFS_IRQ_TWO, 32'hffff0000);
        rdc(OFS_IRQ_TWO, 32'h0, 32'hffff0000, "two upper");
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", last_err, 1);
    endtask
    task automatic t_wake;
        wr(OFS_IRQ_ONE, 32'h8);
        pulse_wake();
        rdc(OFS_IRQ_ONE, 32'h8, '1, "frame out of mode");
        wr(OFS_IRQ_ONE, 32'he);
        cyc(2);
        check("host wake mode", wake_mode_active, 1);
        pulse_wake();
        cyc(2);
        check("summary", {irq_summary, pci_irq_n}, 3);
        wr(OFS_AUX_CTRL, 32'h3f01);
        cyc(2);
        check("line on", pci_irq_n, 0);
        wr(OFS_IRQ_ONE, 32'h6);
        cyc(2);
        check("enable off", {irq_summary, pci_irq_n}, 1);
        wr(OFS_IRQ_ONE, 32'he);
        rdc(OFS_IRQ_ONE, 32'h1e, '1, "w0 keeps flag");
        wr(OFS_IRQ_ONE, rd_v);
        rdc(OFS_IRQ_ONE, 32'he, '1, "write back clears");
        wr(OFS_IRQ_ONE, 32'h2);
        @(posedge clk);
        power_good_input <= 1'b1;
        cyc(5);
        check("power wake mode", wake_mode_active, 1);
        @(posedge clk);
        power_good_input <= 1'b0;
        cyc(5);
        check("mode ends", wake_mode_active, 0);
    endtask
    task automatic t_halt_soft;
        wr(OFS_IRQ_ONE, 32'he);
        pulse_wake();
        wr(OFS_IRQ_TWO, 32'h8000);
        n = reinit_cnt;
        wr(OFS_AUX_CTRL, 32'h3f03);
        rdc(OFS_IRQ_ONE, 32'he, '1, "halt");
        rdc(OFS_IRQ_TWO, 32'h0, 32'h8000, "halt quick");
        wr(OFS_IRQ_ONE, 32'hf);
        cyc(4);
        check("halted", {no_new_work, suspended}, 0);
        check("reinit", reinit_cnt - n, 1);
        wr(OFS_AUX_CTRL, 32'h3f01);
        @(posedge clk);
        mdio_turn_high <= 1'b1;
        @(posedge clk);
        mdio_turn_high <= 1'b0;
        wr(OFS_IRQ_TWO, 32'h100);
        cyc(2);
        check("mre line", pci_irq_n, 0);
        wr(OFS_AUX_CTRL, 32'h3f05);
        rdc(OFS_IRQ_ONE, 32'h0, '1, "soft one");
        rdc(OFS_IRQ_TWO, 32'h300, 32'h300, "soft mre");
        wr(OFS_IRQ_TWO, 32'h200);
        rdc(OFS_IRQ_TWO, 32'h0, 32'h300, "mre clear");
    endtask
    task automatic t_suspend;
        wr(OFS_IRQ_TWO, 32'h8000);
        n = reinit_cnt;
        @(posedge clk);
        start_work <= 1'b1;
        @(posedge clk);
        start_work <= 1'b0;
        wr(OFS_IRQ_ONE, 32'h1);
        cyc(3);
        check("fast", {no_new_work, flush_req, suspended}, 4);
        rdc(OFS_IRQ_ONE, 32'h0, 32'h1, "pending");
        for (int k = 0; k < 30 && suspended !== 1'b1; k++) @(negedge clk);
        check("fast idle", {suspended, dma_active, frame_active}, 4);
        rdc(OFS_IRQ_ONE, 32'h1, 32'h1, "entered");
        wr(OFS_IRQ_ONE, 32'h0);
        cyc(3);
        check("resume", {no_new_work, suspended}, 0);
        check("no reinit", reinit_cnt - n, 0);
        wr(OFS_IRQ_TWO, 32'h0);
        @(posedge clk);
        load_queue <= 1'b1;
        @(posedge clk);
        load_queue <= 1'b0;
        wr(OFS_IRQ_ONE, 32'h1);
        cyc(3);
        check("flush", {flush_req, suspended}, 2);
        for (int k = 0; k < 30 && suspended !== 1'b1; k++) @(negedge clk);
        check("drained", {suspended, tx_queue_empty, rx_buf_empty}, 7);
        wr(OFS_IRQ_ONE, 32'h0);
    endtask
    task automatic t_poll_timer;
        wr(OFS_IRQ_TWO, 32'h3000);
        cyc(2);
        check("rx poll", {rx_poll_go, chain_poll_disable}, 3);
        wr(OFS_IRQ_TWO, 32'h1000);
        rdc(OFS_IRQ_TWO, 32'h3000, 32'h3000, "w0 demand");
        wr(OFS_AUX_CTRL, 32'h3f05);
        rdc(OFS_IRQ_TWO, 32'h1000, 32'h3000, "soft poll");
        @(posedge clk);
        poll_interval_tick <= 1'b1;
        tx_poll_demand <= 1'b1;
        @(posedge clk);
        poll_interval_tick <= 1'b0;
        cyc(2);
        check("manual only", {rx_poll_go, tx_poll_go}, 1);
        @(posedge clk);
        tx_poll_demand <= 1'b0;
        wr(OFS_IRQ_TWO, 32'h3000);
        fetch_en <= 1'b1;
        cyc(5);
        check("fetch clears", rx_poll_go, 0);
        wr(OFS_AUX_CTRL, 32'h0401);
        wr(OFS_IRQ_TWO, 32'hc00);
        for (int k = 0; k < 80 && irq_summary !== 1'b1; k++) @(negedge clk);
        check("timer irq", {irq_summary, pci_irq_n}, 2);
        rdc(OFS_AUX_STAT, 32'h0, 32'h3800, "reloaded");
        wr(OFS_IRQ_TWO, 32'h800);
        cyc(2);
        check("timer off", {irq_summary, pci_irq_n}, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {power_good_input, wake_frame_rx, mdio_turn_high} = '0;
        {tx_poll_demand, poll_interval_tick, start_work} = '0;
        {load_queue, fetch_en} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset_bus();
        t_wake();
        t_halt_soft();
        t_suspend();
        t_poll_timer();
        print_verdict();
    end
endmodule // tb_top
